/* File: hdl/aom_core.sv */
// converter output word, format strap, stabilizer, tri-state and power states
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps

module aom_core #(
	parameter int SLEEP_WAKE_CYC = aom_pkg::AOM_SLEEP_WAKE_CYC,
	parameter int CLK_STOP_CYC   = aom_pkg::AOM_CLK_STOP_CYC
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	// register bus
	input  wire aom_pkg::aom_apb_req_s apb_req,
	output aom_pkg::aom_apb_rsp_s      apb_rsp,
	// converter pins in
	input  wire logic                  sample_clk,
	input  wire logic [15:0]           analog_code,
	input  wire logic [1:0]            mode_strap,
	input  wire logic                  oe_n,
	input  wire logic                  power_down_pin,
	// converter pins out
	output logic [13:0]                conversion_word,
	output logic                       conversion_word_oe,
	output logic                       overrange_flag,
	output logic                       overrange_flag_oe,
	output logic                       data_valid,
	output logic                       hold_phase
);
	import aom_pkg::*;

	typedef struct packed {
		logic        sclk_s1;
		logic        sclk_s2;
		logic        sclk_d;
		logic        oen_s1;
		logic        oen_s2;
		logic        pd_s1;
		logic        pd_s2;
		logic [1:0]  mode_s1;
		logic [1:0]  mode_s2;
		logic [15:0] ain_s1;
		logic [15:0] ain_s2;
		aom_state_e  st;
		logic        wake_slow;
		logic [19:0] wake_cnt;
		logic [11:0] gap_cnt;
		logic [11:0] period;
		logic        int_clk;
		logic        locked;
		logic [6:0]  lock_cnt;
		logic [2:0]  fill;
		logic        out_en;
		logic        valid;
		logic [31:0] ctrl;
		logic [31:0] smp_cnt;
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} aom_core_state_s;

	aom_core_state_s s;
	aom_core_state_s next_s;

	logic        rise;
	logic        shift;
	logic        stab_on;
	logic        twos_fmt;
	logic        over_hi;
	logic        over_lo;
	logic [15:0] biased;
	logic [13:0] ob_code;
	logic [13:0] conv_word;
	logic [14:0] pipe_out;
	logic        low_power;
	logic        access;

	// ****************************************
	// strap decode and conversion
	// ****************************************
	assign rise      = s.sclk_s2 & ~s.sclk_d;
	assign low_power = (s.st == AOM_ST_NAP) || (s.st == AOM_ST_SLEEP);
	assign shift     = rise & ~low_power;
	assign stab_on   = (s.mode_s2 == AOM_STRAP_THIRD) || (s.mode_s2 == AOM_STRAP_TWO3);
	assign twos_fmt  = s.ctrl[AOM_CTRL_OVR_EN] ? s.ctrl[AOM_CTRL_OVR_TWOS] : s.mode_s2[1];

	assign over_hi = $signed(s.ain_s2) > AOM_AIN_MAX;
	assign over_lo = $signed(s.ain_s2) < AOM_AIN_MIN;
	assign biased  = s.ain_s2 + AOM_OB_BIAS;

	always_comb begin
		if (over_hi) begin
			ob_code = AOM_CODE_MAX;
		end else if (over_lo) begin
			ob_code = AOM_CODE_MIN;
		end else begin
			ob_code = biased[13:0];
		end
		conv_word = twos_fmt ? {~ob_code[13], ob_code[12:0]} : ob_code;
	end

	// six edges between hold and output
	aom_pipe #(
		.WIDTH (15),
		.DEPTH (AOM_PIPE_STAGES)
	) u_pipe (
		.clk   (clk),
		.reset (reset),
		.shift (shift),
		.din   ({over_hi | over_lo, conv_word}),
		.dout  (pipe_out)
	);

	assign access = apb_req.psel & apb_req.penable;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.sclk_s1 = sample_clk;
		next_s.sclk_s2 = s.sclk_s1;
		next_s.sclk_d  = s.sclk_s2;
		next_s.oen_s1  = oe_n;
		next_s.oen_s2  = s.oen_s1;
		next_s.pd_s1   = power_down_pin;
		next_s.pd_s2   = s.pd_s1;
		next_s.mode_s1 = mode_strap;
		next_s.mode_s2 = s.mode_s1;
		next_s.ain_s1  = analog_code;
		next_s.ain_s2  = s.ain_s1;

		// period measure and internal half-period fall
		if (rise) begin
			next_s.gap_cnt = 12'h000;
			next_s.period  = 12'(s.gap_cnt + 12'h001);
			next_s.int_clk = 1'b1;
		end else begin
			if (s.gap_cnt != 12'(CLK_STOP_CYC)) begin
				next_s.gap_cnt = 12'(s.gap_cnt + 12'h001);
			end
			if (!stab_on) begin
				next_s.int_clk = s.sclk_s2;
			end else if (12'(s.gap_cnt + 12'h001) >= (s.period >> 1)) begin
				next_s.int_clk = 1'b0;
			end
		end

		// lock lost on long stop, regained after hundred edges
		if (s.gap_cnt == 12'(CLK_STOP_CYC)) begin
			next_s.locked   = 1'b0;
			next_s.lock_cnt = 7'h00;
		end else if (rise && !s.locked) begin
			if (s.lock_cnt == 7'(AOM_DCS_LOCK_CYCLES - 1)) begin
				next_s.locked = 1'b1;
			end else begin
				next_s.lock_cnt = 7'(s.lock_cnt + 7'h01);
			end
		end

		// power state machine
		case (s.st)
			AOM_ST_RUN: begin
				// sleep when output enable high as well
				if (s.pd_s2) begin
					next_s.st = s.oen_s2 ? AOM_ST_SLEEP : AOM_ST_NAP;
				end
			end
			AOM_ST_NAP: begin
				if (s.pd_s2 && s.oen_s2) begin
					next_s.st = AOM_ST_SLEEP;
				end else if (!s.pd_s2) begin
					next_s.st        = AOM_ST_WAKE;
					next_s.wake_slow = 1'b0;
					next_s.wake_cnt  = 20'(AOM_NAP_WAKE_CYCLES);
				end
			end
			AOM_ST_SLEEP: begin
				// reference was off: recovery is the long one
				if (!s.pd_s2) begin
					next_s.st        = AOM_ST_WAKE;
					next_s.wake_slow = 1'b1;
					next_s.wake_cnt  = 20'(SLEEP_WAKE_CYC);
				end
			end
			AOM_ST_WAKE: begin
				if (s.pd_s2) begin
					next_s.st = s.oen_s2 ? AOM_ST_SLEEP : AOM_ST_NAP;
				end else if (s.wake_cnt == 20'h00000) begin
					next_s.st = AOM_ST_RUN;
				end else if (s.wake_slow || rise) begin
					// nap recovery counted in converter clocks
					next_s.wake_cnt = 20'(s.wake_cnt - 20'h00001);
				end
			end
			default: begin
				next_s.st = AOM_ST_RUN;
			end
		endcase

		// pipeline fill tracking; empties across low power
		if (low_power) begin
			next_s.fill = 3'h0;
		end else if (shift && s.fill != 3'(AOM_PIPE_STAGES)) begin
			next_s.fill = 3'(s.fill + 3'h1);
		end

		// no drive in nap or sleep
		next_s.out_en = ~s.oen_s2 & ~low_power;
		next_s.valid  = (s.st == AOM_ST_RUN) && (s.locked || !stab_on)
			&& (s.fill == 3'(AOM_PIPE_STAGES));

		// ****************************************
		// register bus
		// ****************************************
		next_s.ack = 1'b0;
		if (access && !s.ack) begin
			next_s.ack   = 1'b1;
			next_s.err   = 1'b0;
			next_s.rdata = 32'h0000_0000;
			if (apb_req.paddr == AOM_REG_CTRL) begin
				next_s.rdata = s.ctrl;
			end else if (apb_req.paddr == AOM_REG_STATUS) begin
				next_s.rdata[AOM_STAT_STATE +: 2] = s.st;
				next_s.rdata[AOM_STAT_TWOS]       = twos_fmt;
				next_s.rdata[AOM_STAT_STAB]       = stab_on;
				next_s.rdata[AOM_STAT_LOCKED]     = s.locked;
				next_s.rdata[AOM_STAT_VALID]      = s.valid;
				next_s.rdata[AOM_STAT_PHASE]      = s.int_clk;
			end else if (apb_req.paddr == AOM_REG_SAMPLE) begin
				next_s.rdata[14:0] = pipe_out;
			end else if (apb_req.paddr == AOM_REG_COUNT) begin
				next_s.rdata = s.smp_cnt;
			end else begin
				next_s.err = 1'b1;
			end
		end

		// a new sample on the clearing edge still counts
		if (access && s.ack && apb_req.pwrite && !s.err
			&& apb_req.paddr == AOM_REG_COUNT) begin
			next_s.smp_cnt = {31'h0, shift & s.valid};
		end else if (shift && s.valid) begin
			next_s.smp_cnt = 32'(s.smp_cnt + 32'h1);
		end
		if (access && s.ack && apb_req.pwrite && !s.err
			&& apb_req.paddr == AOM_REG_CTRL) begin
			next_s.ctrl = {30'h0, apb_req.pwdata[1:0]};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s          <= '0;
			s.st       <= AOM_ST_RUN;
			s.ctrl     <= AOM_CTRL_RST;
			s.period   <= 12'h002;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign conversion_word    = pipe_out[13:0];
	assign overrange_flag     = pipe_out[14];
	// word and flag share one enable
	assign conversion_word_oe = s.out_en;
	assign overrange_flag_oe  = s.out_en;
	assign data_valid         = s.valid;
	// hold while high, track while low
	assign hold_phase         = s.int_clk;
	assign apb_rsp.prdata     = s.rdata;
	assign apb_rsp.pready     = s.ack;
	assign apb_rsp.pslverr    = s.ack & s.err;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_ob_midscale: assert property (
		!twos_fmt && s.ain_s2 == 16'h0000 |-> conv_word == AOM_CODE_MID)
		else $error("offset binary zero input not midscale");

	a_twos_full: assert property (
		twos_fmt && over_hi |-> conv_word == AOM_TWOS_MAX && ob_code == AOM_CODE_MAX)
		else $error("two's complement positive full scale wrong");

	a_ovr_sat: assert property (
		shift && over_lo && !twos_fmt |=> u_pipe.s.stage[0] == {1'b1, AOM_CODE_MIN})
		else $error("underrange not saturated with flag");

	a_strap_dec: assert property (
		s.mode_s2 == AOM_STRAP_VDD && !s.ctrl[AOM_CTRL_OVR_EN] |-> twos_fmt && !stab_on)
		else $error("supply strap decoded wrongly");

	a_dcs_rise: assert property (
		stab_on && rise |=> s.int_clk ##1 (s.int_clk || rise || $past(rise)))
		else $error("internal phase not started on rising edge");

	a_lock_stop: assert property (
		s.gap_cnt == 12'(CLK_STOP_CYC) && stab_on |=> ##1 !s.valid)
		else $error("data marked valid after clock stop");

	a_oe_hiz: assert property (
		s.oen_s2 |=> !conversion_word_oe && !overrange_flag_oe)
		else $error("outputs driven while output enable high");

	a_nap_entry: assert property (
		s.st == AOM_ST_RUN && s.pd_s2 && !s.oen_s2 |=> s.st == AOM_ST_NAP)
		else $error("nap not entered");

	a_sleep_entry: assert property (
		s.st == AOM_ST_RUN && s.pd_s2 && s.oen_s2 |=> s.st == AOM_ST_SLEEP)
		else $error("sleep not entered");

	a_lowpwr_hiz: assert property (
		low_power |=> !conversion_word_oe)
		else $error("outputs driven in low power");

	a_run_shift: assert property (
		s.st == AOM_ST_RUN && rise |-> shift)
		else $error("edge in normal operation not converted");

	c_nap_wake: cover property (s.st == AOM_ST_WAKE && !s.wake_slow ##1 s.st == AOM_ST_RUN);
	c_sleep: cover property (s.st == AOM_ST_SLEEP);
	c_overrange: cover property (shift && over_hi);
	c_relock: cover property (stab_on && $rose(s.locked));

endmodule

/* File: hdl/aom_pkg.sv */
// shared constants, types and carriers for the converter output and mode control
package aom_pkg;

	// ****************************************
	// data path
	// ****************************************
	localparam int                 AOM_WORD_W     = 14;
	localparam int                 AOM_AIN_W      = 16;
	localparam int                 AOM_PIPE_STAGES = 6;
	localparam logic [13:0]        AOM_CODE_MAX   = 14'h3fff;
	localparam logic [13:0]        AOM_CODE_MIN   = 14'h0000;
	localparam logic [13:0]        AOM_CODE_MID   = 14'h2000;
	localparam logic [13:0]        AOM_TWOS_MAX   = 14'h1fff;
	localparam logic [13:0]        AOM_TWOS_MIN   = 14'h2000;
	localparam logic [15:0]        AOM_OB_BIAS    = 16'h2000;
	localparam logic signed [15:0] AOM_AIN_MAX    = 16'sh1fff;
	localparam logic signed [15:0] AOM_AIN_MIN    = 16'she000;

	// ****************************************
	// timing
	// ****************************************
	localparam int AOM_CLK_PERIOD_NS   = 4;
	localparam int AOM_DCS_LOCK_CYCLES = 100;
	localparam int AOM_NAP_WAKE_CYCLES = 100;
	localparam int AOM_SLEEP_WAKE_MS   = 2;
	localparam int AOM_SLEEP_WAKE_CYC  = AOM_SLEEP_WAKE_MS * 1000000 / AOM_CLK_PERIOD_NS;
	localparam int AOM_CLK_STOP_NS     = 10000;
	localparam int AOM_CLK_STOP_CYC    = AOM_CLK_STOP_NS / AOM_CLK_PERIOD_NS;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] AOM_REG_CTRL   = 12'h000;
	localparam logic [11:0] AOM_REG_STATUS = 12'h004;
	localparam logic [11:0] AOM_REG_SAMPLE = 12'h008;
	localparam logic [11:0] AOM_REG_COUNT  = 12'h00c;
	localparam logic [31:0] AOM_CTRL_RST   = 32'h0000_0000;
	localparam int          AOM_CTRL_OVR_EN   = 0;
	localparam int          AOM_CTRL_OVR_TWOS = 1;
	localparam int          AOM_STAT_STATE    = 0;
	localparam int          AOM_STAT_TWOS     = 2;
	localparam int          AOM_STAT_STAB     = 3;
	localparam int          AOM_STAT_LOCKED   = 4;
	localparam int          AOM_STAT_VALID    = 5;
	localparam int          AOM_STAT_PHASE    = 6;

	typedef enum logic [1:0] {
		AOM_STRAP_GND   = 2'b00,
		AOM_STRAP_THIRD = 2'b01,
		AOM_STRAP_TWO3  = 2'b10,
		AOM_STRAP_VDD   = 2'b11
	} aom_strap_e;

	typedef enum logic [1:0] {
		AOM_ST_RUN   = 2'b00,
		AOM_ST_NAP   = 2'b01,
		AOM_ST_SLEEP = 2'b10,
		AOM_ST_WAKE  = 2'b11
	} aom_state_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} aom_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} aom_apb_rsp_s;

endpackage

/* File: hdl/aom_pipe.sv */
// delay line standing in for the six conversion stages
`timescale 1ns/10ps
module aom_pipe #(
	parameter int WIDTH = 15,
	parameter int DEPTH = aom_pkg::AOM_PIPE_STAGES
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// stream
	input  wire logic             shift,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	import aom_pkg::*;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] stage;
	} aom_pipe_state_s;

	aom_pipe_state_s             s;
	aom_pipe_state_s             next_s;
	logic [DEPTH-1:0][WIDTH-1:0] next_stage;

	// ****************************************
	// stages
	// ****************************************
	assign next_stage[0] = shift ? din : s.stage[0];
	for (genvar i = 1; i < DEPTH; i++) begin : g_stage
		assign next_stage[i] = shift ? s.stage[i-1] : s.stage[i];
	end

	always_comb begin
		next_s       = s;
		next_s.stage = next_stage;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign dout = s.stage[DEPTH-1];

endmodule

/* File: sim/aom_capture.sv */
// capture-side model: sample clock source and word latch
`timescale 1ns/10ps
module aom_capture (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// clock source control
	input  wire logic        run,
	input  wire logic [7:0]  hi_cyc,
	input  wire logic [7:0]  lo_cyc,
	output logic             sample_clk,
	output logic             rise_stb,
	output logic             fall_stb,
	// converter outputs
	input  wire logic [13:0] conversion_word,
	input  wire logic        overrange_flag,
	input  wire logic        word_oe,
	input  wire logic        data_valid,
	output logic [14:0]      cap,
	output logic             cap_oe,
	output logic             cap_valid
);
	logic [7:0] cnt;

	// ****************************************
	// clock source and latch
	// ****************************************
	// stopped clock rests low, so a restart always begins with a full low phase
	always_ff @(posedge clk) begin
		rise_stb <= 1'b0;
		fall_stb <= 1'b0;
		if (reset || !run) begin
			sample_clk <= 1'b0;
			cnt        <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
			// bench keeps halves at 6..20 clk, period 26 clk
			if (sample_clk && cnt + 8'h01 >= hi_cyc) begin
				sample_clk <= 1'b0;
				cnt        <= 8'h00;
				fall_stb   <= 1'b1;
				// word and flag latched on one edge
				cap        <= {overrange_flag, conversion_word};
				cap_oe     <= word_oe;
				cap_valid  <= data_valid;
			end else if (!sample_clk && cnt + 8'h01 >= lo_cyc) begin
				sample_clk <= 1'b1;
				cnt        <= 8'h00;
				rise_stb   <= 1'b1;
			end
		end
	end
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the converter output and mode control
`timescale 1ns/10ps
module tb_top;
	import aom_pkg::*;
	logic         clk, reset, run, oe_n, power_down_pin, sample_clk, rise_stb, fall_stb;
	logic         word_oe, flag_oe, data_valid, hold_phase, overrange_flag, cap_oe, cap_valid, err;
	logic [1:0]   strap;
	logic [7:0]   hi, lo;
	logic [13:0]  conversion_word;
	logic [14:0]  cap, e;
	logic [15:0]  ain;
	logic [31:0]  rd;
	logic [14:0]  q[$];
	int           errors, n_compared, rises, cycles;
	aom_apb_req_s req;
	aom_apb_rsp_s rsp;

	aom_core #(.SLEEP_WAKE_CYC(200), .CLK_STOP_CYC(300)) dut (.clk(clk), .reset(reset),
		.apb_req(req), .apb_rsp(rsp), .sample_clk(sample_clk), .analog_code(ain),
		.mode_strap(strap), .oe_n(oe_n), .power_down_pin(power_down_pin),
		.conversion_word(conversion_word), .conversion_word_oe(word_oe),
		.overrange_flag(overrange_flag), .overrange_flag_oe(flag_oe),
		.data_valid(data_valid), .hold_phase(hold_phase));
	aom_capture cap_model (.clk(clk), .reset(reset), .run(run), .hi_cyc(hi), .lo_cyc(lo),
		.sample_clk(sample_clk), .rise_stb(rise_stb), .fall_stb(fall_stb),
		.conversion_word(conversion_word), .overrange_flag(overrange_flag),
		.word_oe(word_oe), .data_valid(data_valid), .cap(cap), .cap_oe(cap_oe),
		.cap_valid(cap_valid));

	// ****************************************
	// helpers
	// ****************************************
	initial clk = 1'b0;
	always #2 clk = ~clk;

	function automatic logic [14:0] exp_code(input logic [15:0] a, input logic twos);
		int   v;
		logic f;
		logic [13:0] w;
		v = $signed(a);
		f = 1'b0;
		if (v > 8191) begin
			v = 8191;
			f = 1'b1;
		end else if (v < -8192) begin
			v = -8192;
			f = 1'b1;
		end
		w = 14'(v + 8192);
		w[13] = w[13] ^ twos;
		return {f, w};
	endfunction

	function automatic logic [15:0] rnd_ain();
		logic [15:0] edges [6] = '{16'h1fff, 16'h2000, 16'he000, 16'hdfff, 16'h0000, 16'hffff};
		if ($urandom_range(3) == 0)
			return edges[$urandom_range(5)];
		return 16'(int'($urandom_range(19999)) - 10000);
	endfunction

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] got);
		n_compared++;
		if (got !== x) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= wr;
		req.paddr   <= a;
		req.pwdata  <= wd;
		@(posedge clk);
		req.penable <= 1'b1;
		@(posedge clk);
		while (rsp.pready !== 1'b1)
			@(posedge clk);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic reg_chk(input string n, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(n, x, rd & m);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wait_rises(input int n);
		int t;
		t = rises + n;
		while (rises < t)
			@(posedge clk);
	endtask

	// one cycle after a fall nothing on the stream moves
	task automatic at_quiet();
		@(posedge clk iff fall_stb);
		@(posedge clk);
	endtask

	task automatic oe_chk(input string n, input logic [1:0] x);
		chk(n, 32'(x), 32'({word_oe, flag_oe}));
	endtask

	task automatic dv_chk(input string n, input logic x);
		chk(n, 32'(x), 32'(data_valid));
	endtask

	// ****************************************
	// reference model and run
	// ****************************************
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end

	always @(posedge clk) begin
		if (rise_stb) begin
			q.push_back(exp_code(ain, strap[1]));
			rises <= rises + 1;
		end
		if (fall_stb) begin
			ain <= rnd_ain();
			if (q.size() == 6) begin
				e = q.pop_front();
				if (cap_valid === 1'b1 && cap_oe === 1'b1)
					chk("word", 32'(e), 32'(cap));
			end
		end
	end

	initial begin
		{reset, req, ain, strap, oe_n, power_down_pin, run} = '1;
		{req, ain, strap, oe_n, power_down_pin, run} = '0;
		{hi, lo, errors, n_compared, rises, cycles} = {8'd13, 8'd13, 128'h0};
		void'($urandom(32'hf3a715fe));
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		reg_chk("ctrl reset", AOM_REG_CTRL, 32'hffffffff, 32'h0);
		apb(1'b1, AOM_REG_CTRL, 32'h3);
		reg_chk("ovr twos", AOM_REG_STATUS, 32'h4, 32'h4);
		reg_chk("ctrl rw", AOM_REG_CTRL, 32'h3, 32'h3);
		apb(1'b1, AOM_REG_CTRL, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", 32'h3, 32'({err, rd == 32'h0}));
		$display("test registers done");
		run <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			at_quiet();
			strap <= 2'(s);
			hi <= (s == 1 || s == 2) ? 8'd6 : 8'd13;
			lo <= (s == 1 || s == 2) ? 8'd20 : 8'd13;
			q.delete();
			wait_rises(12);
			@(posedge clk iff rise_stb);
			cyc(10);
			chk("hold high", 32'h1, 32'(hold_phase));
			cyc(11);
			chk("hold low", 32'h0, 32'(hold_phase));
			reg_chk("mode", AOM_REG_STATUS, 32'hf, 32'({s == 1 || s == 2, s >= 2, 2'b00}));
			$display("test strap %0d done", s);
		end
		at_quiet();
		apb(1'b1, AOM_REG_COUNT, 32'h0);
		wait_rises(3);
		cyc(4);
		reg_chk("count", AOM_REG_COUNT, 32'hffffffff, 32'h3);
		oe_n <= 1'b1;
		cyc(8);
		oe_chk("oe off", 2'b00);
		oe_n <= 1'b0;
		cyc(8);
		oe_chk("oe on", 2'b11);
		at_quiet();
		power_down_pin <= 1'b1;
		cyc(20);
		oe_chk("nap oe", 2'b00);
		reg_chk("nap state", AOM_REG_STATUS, 32'h3, 32'h1);
		at_quiet();
		power_down_pin <= 1'b0;
		q.delete();
		wait_rises(90);
		dv_chk("nap wait", 1'b0);
		wait_rises(16);
		dv_chk("nap back", 1'b1);
		$display("test nap done");
		at_quiet();
		power_down_pin <= 1'b1;
		cyc(20);
		oe_n <= 1'b1;
		cyc(20);
		reg_chk("sleep state", AOM_REG_STATUS, 32'h3, 32'h2);
		oe_chk("sleep oe", 2'b00);
		at_quiet();
		power_down_pin <= 1'b0;
		q.delete();
		cyc(20);
		oe_n <= 1'b0;
		cyc(160);
		dv_chk("sleep wait", 1'b0);
		cyc(120);
		dv_chk("sleep back", 1'b1);
		$display("test sleep done");
		at_quiet();
		{strap, hi, lo} <= {2'b01, 8'd6, 8'd20};
		q.delete();
		wait_rises(12);
		at_quiet();
		run <= 1'b0;
		cyc(400);
		run <= 1'b1;
		wait_rises(90);
		dv_chk("relock wait", 1'b0);
		wait_rises(16);
		dv_chk("relock done", 1'b1);
		$display("test relock done");
		summarize();
	end
endmodule
